// file: logic/isp_host.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] Enable instruction is sent first after reset low; others except end refused until enabled.
// [R2] Data-in changes on falling clock so device samples it on rising edge.
// [R3] Data-out is captured on the rising edge of the serial clock.
// [R4] Each clock phase lasts 40 system cycles, far beyond three device cycles.
// [R5] Clock is held low, then reset pulsed high for 200 cycles.
// [R6] At least 20 ms passes after reset low before the enable instruction.
// [R7] The byte returned during byte three of enable must equal 53.
// [R8] All four enable bytes always sent; wrong echo pulses reset and returns an error, and the user must send enable again.
// [R9] Chip erase sends AC 80 00 00.
// [R10] Page load sends 40 or 48 with word index in low six bits.
// [R11] High byte load refused unless the low byte of that word was just loaded.
// [R12] Page write sends 4C with page number in the upper seven bits.
// [R13] After page write the host always waits 4.5 ms, with no polling.
// [R14] EEPROM writes need no prior erase; host sends them directly.
// [R15] EEPROM write sends C0 address data, then waits 9.0 ms.
// [R16] Polled flash reads return FF until the page write finishes.
// [R17] FF page data cannot be polled; fixed wait is always used here.
// [R18] Polled EEPROM reads return FF until the byte is written.
// [R19] Reads 20, 28, A0 return data in the fourth byte.
// [R20] Poll F0 returns busy in bit zero; user retries until clear.
// [R21] Lock and fuse writes send AC E0, A0 or A8 with data in byte four.
// [R22] Host waits 4.5 ms after fuse or lock writes, 9.0 ms after erase.
// [R23] End command drives reset high, leaving programming mode.
// [R24] Four bytes per instruction, most significant bit first.
module isp_host #(
  parameter int unsigned POWERUP_CYC     = isp_pkg::POWERUP_CYC,
  parameter int unsigned FLASH_WAIT_CYC  = isp_pkg::FLASH_WAIT_CYC,
  parameter int unsigned FUSE_WAIT_CYC   = isp_pkg::FUSE_WAIT_CYC,
  parameter int unsigned EEPROM_WAIT_CYC = isp_pkg::EEPROM_WAIT_CYC,
  parameter int unsigned ERASE_WAIT_CYC  = isp_pkg::ERASE_WAIT_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       cmd_valid,
  input  wire logic [3:0] cmd_op,
  input  wire logic [15:0] cmd_addr,
  input  wire logic [7:0] cmd_data,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            rsp_err,
  output logic            prog_enabled,
  output logic            isp_sck,
  output logic            isp_mosi,
  output logic            isp_reset,
  input  wire logic       isp_miso
);
  // ---------------------------------------------------------------
  // Types and state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ISP_ST_PWR, ISP_ST_RSTHI, ISP_ST_WAIT, ISP_ST_IDLE, ISP_ST_LOW,
    ISP_ST_HIGH, ISP_ST_DONE, ISP_ST_HOLD, ISP_ST_OFF
  } isp_state_e;

  isp_state_e  st_q;
  logic [31:0] cnt_q;
  logic [1:0]  byte_q;
  logic [2:0]  bit_q;
  logic [31:0] tx_q;
  logic [7:0]  rx_q;
  logic [7:0]  echo_q;
  logic [3:0]  op_q;
  logic [31:0] hold_q;
  logic        miso_s;
  logic        timer_load;
  logic        timer_done;
  logic [31:0] timer_count;
  logic [5:0]  lo_word_q;
  logic        lo_vld_q;

  isp_sync u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     (isp_miso),
    .dout    (miso_s)
  );

  isp_timer u_timer (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .load    (timer_load),
    .count   (timer_count),
    .done    (timer_done)
  );

  // ---------------------------------------------------------------
  // Instruction encoding
  // ---------------------------------------------------------------
  function automatic logic [31:0] isp_frame(input logic [3:0] op, input logic [15:0] a,
                                            input logic [7:0] d);
    logic [31:0] f;
    f = 32'h0;
    case (isp_pkg::isp_cmd_e'(op))
      isp_pkg::ISP_CMD_ENABLE:     f = {isp_pkg::OP_ENABLE, isp_pkg::SUB_ENABLE, 16'h0}; // [R1]
      isp_pkg::ISP_CMD_ERASE:      f = {isp_pkg::OP_ENABLE, isp_pkg::SUB_ERASE, 16'h0}; // [R9]
      isp_pkg::ISP_CMD_POLL:       f = {isp_pkg::OP_POLL, 24'h0}; // [R20]
      isp_pkg::ISP_CMD_LOAD_LO:    f = {isp_pkg::OP_LOAD_LO, 10'h0, a[5:0], d}; // [R10]
      isp_pkg::ISP_CMD_LOAD_HI:    f = {isp_pkg::OP_LOAD_HI, 10'h0, a[5:0], d}; // [R10]
      isp_pkg::ISP_CMD_WR_PAGE:    f = {isp_pkg::OP_WR_PAGE, 3'h0, a[12:6], 6'h0, 8'h0}; // [R12]
      isp_pkg::ISP_CMD_RD_LO:      f = {isp_pkg::OP_RD_LO, a, 8'h0}; // [R19]
      isp_pkg::ISP_CMD_RD_HI:      f = {isp_pkg::OP_RD_HI, a, 8'h0}; // [R19]
      isp_pkg::ISP_CMD_RD_EE:      f = {isp_pkg::OP_RD_EE, a, 8'h0}; // [R19]
      isp_pkg::ISP_CMD_WR_EE:      f = {isp_pkg::OP_WR_EE, a, d}; // [R14] [R15]
      isp_pkg::ISP_CMD_WR_LOCK:    f = {isp_pkg::OP_ENABLE, isp_pkg::SUB_LOCK, 8'h0, d}; // [R21]
      isp_pkg::ISP_CMD_WR_FUSE_LO: f = {isp_pkg::OP_ENABLE, isp_pkg::SUB_FUSE_LO, 8'h0, d}; // [R21]
      isp_pkg::ISP_CMD_WR_FUSE_HI: f = {isp_pkg::OP_ENABLE, isp_pkg::SUB_FUSE_HI, 8'h0, d}; // [R21]
      default:                     f = 32'h0;
    endcase
    return f;
  endfunction : isp_frame

  // Fixed waits are always used, since polling cannot see an FF result
  function automatic logic [31:0] isp_wait(input logic [3:0] op);
    logic [31:0] w;
    w = 32'h1;
    case (isp_pkg::isp_cmd_e'(op))
      isp_pkg::ISP_CMD_ERASE:      w = ERASE_WAIT_CYC; // [R22]
      isp_pkg::ISP_CMD_WR_PAGE:    w = FLASH_WAIT_CYC; // [R13] [R17]
      isp_pkg::ISP_CMD_WR_EE:      w = EEPROM_WAIT_CYC; // [R15]
      isp_pkg::ISP_CMD_WR_LOCK,
      isp_pkg::ISP_CMD_WR_FUSE_LO,
      isp_pkg::ISP_CMD_WR_FUSE_HI: w = FUSE_WAIT_CYC; // [R22]
      default:                     w = 32'h1;
    endcase
    return w;
  endfunction : isp_wait

  wire logic is_enable = (op_q == 4'(isp_pkg::ISP_CMD_ENABLE));
  wire logic accept    = (st_q == ISP_ST_IDLE) && cmd_valid;
  wire logic hi_ok     = (cmd_op != 4'(isp_pkg::ISP_CMD_LOAD_HI))
                         || (lo_vld_q && (cmd_addr[5:0] == lo_word_q)); // [R11]
  wire logic cmd_ok    = (prog_enabled && hi_ok) || (cmd_op == 4'(isp_pkg::ISP_CMD_ENABLE))
                         || (cmd_op == 4'(isp_pkg::ISP_CMD_END));
  wire logic last_bit  = (byte_q == 2'd3) && (bit_q == 3'd7);
  wire logic echo_bad  = (echo_q != isp_pkg::SUB_ENABLE);

  assign timer_load  = (st_q == ISP_ST_DONE);
  assign timer_count = isp_wait(op_q);

  // ---------------------------------------------------------------
  // Word pairing, a high byte only follows the low byte of its word
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lo_word_q <= 6'h00;
      lo_vld_q  <= 1'b0;
    end else if (accept && cmd_ok) begin
      // Any other accepted command breaks the pair, so a stale low byte is never reused
      lo_vld_q  <= (cmd_op == 4'(isp_pkg::ISP_CMD_LOAD_LO)); // [R11]
      lo_word_q <= cmd_addr[5:0];
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_q   <= ISP_ST_PWR;
      cnt_q  <= 32'h0;
      byte_q <= 2'd0;
      bit_q  <= 3'd0;
      tx_q   <= 32'h0;
      op_q   <= 4'h0;
    end else begin
      case (st_q)
        ISP_ST_PWR: begin
          // Clock already low, so a reset pulse guards against a glitched start
          cnt_q <= 32'(isp_pkg::RST_PULSE_CYC);
          st_q  <= ISP_ST_RSTHI; // [R5]
        end
        ISP_ST_RSTHI: begin
          if (cnt_q == 32'h1) begin
            cnt_q <= POWERUP_CYC;
            st_q  <= ISP_ST_WAIT;
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        ISP_ST_WAIT: begin
          if (cnt_q <= 32'h1) begin
            st_q <= ISP_ST_IDLE; // [R6]
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        ISP_ST_IDLE: begin
          if (accept && cmd_ok) begin
            op_q   <= cmd_op;
            tx_q   <= isp_frame(cmd_op, cmd_addr, cmd_data);
            byte_q <= 2'd0;
            bit_q  <= 3'd0;
            cnt_q  <= 32'(isp_pkg::SCK_HALF_CYC);
            if (cmd_op == 4'(isp_pkg::ISP_CMD_END)) begin
              st_q <= ISP_ST_OFF; // [R23]
            end else begin
              st_q <= ISP_ST_LOW;
            end
          end
        end
        ISP_ST_LOW: begin
          if (cnt_q == 32'h1) begin
            cnt_q <= 32'(isp_pkg::SCK_HALF_CYC);
            st_q  <= ISP_ST_HIGH; // [R4]
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        ISP_ST_HIGH: begin
          if (cnt_q == 32'h1) begin
            cnt_q <= 32'(isp_pkg::SCK_HALF_CYC);
            tx_q  <= {tx_q[30:0], 1'b0}; // [R24]
            bit_q <= bit_q + 3'd1;
            if (bit_q == 3'd7) begin
              byte_q <= byte_q + 2'd1;
            end
            st_q <= last_bit ? ISP_ST_DONE : ISP_ST_LOW; // [R8]
          end else begin
            cnt_q <= cnt_q - 32'h1;
          end
        end
        ISP_ST_DONE: begin
          st_q <= ISP_ST_HOLD;
        end
        ISP_ST_HOLD: begin
          if (timer_done) begin
            if (is_enable && echo_bad) begin
              cnt_q <= 32'(isp_pkg::RST_PULSE_CYC);
              st_q  <= ISP_ST_RSTHI; // [R8]
            end else begin
              st_q <= ISP_ST_IDLE;
            end
          end
        end
        ISP_ST_OFF: begin
          st_q <= ISP_ST_OFF;
        end
        default: begin
          st_q <= ISP_ST_PWR;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Receive shifter, sampled at the rising clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rx_q   <= 8'h0;
      echo_q <= 8'h0;
    end else if (st_q == ISP_ST_HIGH && cnt_q == 32'(isp_pkg::SCK_HALF_CYC)) begin
      // Synchroniser delay is covered by the long low phase before this sample
      rx_q <= {rx_q[6:0], miso_s}; // [R3]
      if (byte_q == 2'd2 && bit_q == 3'd7) begin
        echo_q <= {rx_q[6:0], miso_s}; // [R7]
      end
    end
  end

  // ---------------------------------------------------------------
  // Pins and responses
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      isp_sck   <= 1'b0;
      isp_mosi  <= 1'b0;
      isp_reset <= 1'b0;
    end else begin
      isp_sck   <= (st_q == ISP_ST_HIGH); // [R4]
      isp_mosi  <= tx_q[31]; // [R2]
      isp_reset <= (st_q == ISP_ST_RSTHI) || (st_q == ISP_ST_OFF); // [R5] [R23]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      prog_enabled <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_data     <= 8'h0;
      rsp_err      <= 1'b0;
      cmd_ready    <= 1'b0;
    end else begin
      cmd_ready <= (st_q == ISP_ST_IDLE) && !cmd_valid;
      rsp_valid <= 1'b0;
      if (accept && !cmd_ok) begin
        rsp_valid <= 1'b1; // [R1]
        rsp_err   <= 1'b1;
        rsp_data  <= 8'h0;
      end else if (st_q == ISP_ST_HOLD && timer_done) begin
        rsp_valid <= 1'b1; // [R16] [R18] [R19] [R20]
        rsp_data  <= rx_q;
        rsp_err   <= is_enable && echo_bad;
        if (is_enable && !echo_bad) begin
          prog_enabled <= 1'b1;
        end
      end
      if (st_q == ISP_ST_RSTHI || st_q == ISP_ST_OFF) begin
        prog_enabled <= 1'b0;
      end
    end
  end
endmodule : isp_host
`default_nettype wire

// file: logic/isp_pkg.sv
package isp_pkg;
  // ---------------------------------------------------------------
  // Link timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned SCK_HALF_CYC    = 40;
  localparam int unsigned RST_PULSE_CYC   = 200;
  localparam int unsigned POWERUP_MS      = 20;
  localparam int unsigned FLASH_WAIT_US   = 4500;
  localparam int unsigned FUSE_WAIT_US    = 4500;
  localparam int unsigned EEPROM_WAIT_US  = 9000;
  localparam int unsigned ERASE_WAIT_US   = 9000;
  localparam int unsigned POWERUP_CYC     = POWERUP_MS * (CLK_HZ / 1000);
  localparam int unsigned FLASH_WAIT_CYC  = FLASH_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FUSE_WAIT_CYC   = FUSE_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned EEPROM_WAIT_CYC = EEPROM_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ERASE_WAIT_CYC  = ERASE_WAIT_US * (CLK_HZ / 1_000_000);
  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_ENABLE    = 8'hac;
  localparam logic [7:0] SUB_ENABLE   = 8'h53;
  localparam logic [7:0] SUB_ERASE    = 8'h80;
  localparam logic [7:0] SUB_LOCK     = 8'he0;
  localparam logic [7:0] SUB_FUSE_LO  = 8'ha0;
  localparam logic [7:0] SUB_FUSE_HI  = 8'ha8;
  localparam logic [7:0] OP_POLL      = 8'hf0;
  localparam logic [7:0] OP_LOAD_LO   = 8'h40;
  localparam logic [7:0] OP_LOAD_HI   = 8'h48;
  localparam logic [7:0] OP_WR_PAGE   = 8'h4c;
  localparam logic [7:0] OP_RD_LO     = 8'h20;
  localparam logic [7:0] OP_RD_HI     = 8'h28;
  localparam logic [7:0] OP_RD_EE     = 8'ha0;
  localparam logic [7:0] OP_WR_EE     = 8'hc0;
  localparam int unsigned BUSY_BIT    = 0;
  // ---------------------------------------------------------------
  // Commands from user
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ISP_CMD_ENABLE, ISP_CMD_ERASE, ISP_CMD_POLL, ISP_CMD_LOAD_LO, ISP_CMD_LOAD_HI,
    ISP_CMD_WR_PAGE, ISP_CMD_RD_LO, ISP_CMD_RD_HI, ISP_CMD_RD_EE, ISP_CMD_WR_EE,
    ISP_CMD_WR_LOCK, ISP_CMD_WR_FUSE_LO, ISP_CMD_WR_FUSE_HI, ISP_CMD_END
  } isp_cmd_e;
endpackage : isp_pkg

// file: logic/isp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module isp_sync (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : isp_sync
`default_nettype wire

// file: logic/isp_timer.sv
`timescale 1ns/1ps
`default_nettype none
module isp_timer (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        load,
  input  wire logic [31:0] count,
  output logic             done
);
  // ---------------------------------------------------------------
  // Down counter, done is a level while expired
  // ---------------------------------------------------------------
  logic [31:0] cnt_q;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cnt_q <= 32'h0;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != 32'h0) begin
      cnt_q <= cnt_q - 32'h1;
    end
  end
  assign done = (cnt_q == 32'h0) && !load;
endmodule : isp_timer
`default_nettype wire

// file: verification/isp_host_props.sv
`timescale 1ns/1ps
`default_nettype none
module isp_host_props #(
  parameter int unsigned POWERUP_CYC = 50
) (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       cmd_valid,
  input wire logic [3:0] cmd_op,
  input wire logic       cmd_ready,
  input wire logic       rsp_valid,
  input wire logic       rsp_err,
  input wire logic       prog_enabled,
  input wire logic       isp_sck,
  input wire logic       isp_mosi,
  input wire logic       isp_reset
);
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  logic        sck_q;
  logic [5:0]  bits_q;
  logic [31:0] low_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk_sys) sck_q <= isp_sck;
  // A bad echo ends a frame with an error response, and the reset pulse clears too
  always_ff @(posedge clk_sys) begin
    if (!nrst || rsp_valid || isp_reset) bits_q <= 6'h00;
    else if (isp_sck && !sck_q) bits_q <= bits_q + 6'h01;
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst || isp_reset) low_q <= 32'h0;
    else if (low_q < POWERUP_CYC) low_q <= low_q + 32'h1;
  end
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  property p_reset_clear; $rose(nrst) |-> !prog_enabled && !isp_reset && !isp_sck; endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared");
  property p_mosi_hold; isp_sck && $past(isp_sck) |-> $stable(isp_mosi); endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("data moved while clock high");
  property p_sck_high; $rose(isp_sck) |-> isp_sck [*8]; endproperty
  a_sck_high: assert property (p_sck_high) else $error("clock high phase short");
  property p_sck_low; $fell(isp_sck) |-> !isp_sck [*8]; endproperty
  a_sck_low: assert property (p_sck_low) else $error("clock low phase short");
  property p_rst_pulse; $rose(isp_reset) |-> (isp_reset && !isp_sck) [*8]; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse short or clock high");
  property p_powerup; $rose(isp_sck) |-> low_q >= POWERUP_CYC; endproperty
  a_powerup: assert property (p_powerup) else $error("frame too soon after reset");
  property p_refuse;
    cmd_valid && cmd_ready && !prog_enabled && cmd_op != isp_pkg::ISP_CMD_ENABLE
      && cmd_op != isp_pkg::ISP_CMD_END |-> ##[1:3] rsp_valid && rsp_err;
  endproperty
  a_refuse: assert property (p_refuse) else $error("command not refused");
  property p_ok_enabled; rsp_valid && !rsp_err |-> ##[0:2] prog_enabled; endproperty
  a_ok_enabled: assert property (p_ok_enabled) else $error("success while disabled");
  property p_frame_len; rsp_valid && !rsp_err |-> bits_q == 6'd32; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not 32 bits");
endmodule : isp_host_props
bind isp_host isp_host_props #(.POWERUP_CYC(POWERUP_CYC)) u_props (
  .clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
  .prog_enabled(prog_enabled), .isp_sck(isp_sck), .isp_mosi(isp_mosi), .isp_reset(isp_reset)
);
`default_nettype wire

// file: verification/isp_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module isp_dev_model #(
  parameter realtime BUSY_NS = 300.0
) (
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic rst,
  input  wire logic bad_echo,
  output logic      miso
);
  logic [31:0] sh;
  logic [7:0]  ob;
  logic        o_q = 1'b0;
  logic        en_q = 1'b0;
  logic [7:0]  fz_q [3];
  logic [15:0] pb [64] = '{default: 16'hffff};
  logic [15:0] fl [int];
  logic [7:0]  ee [int];
  int          n = 0;
  realtime     busy_t = 0.0;
  // Released line shows the inverse, never a stale value
  assign miso = rst ? ~o_q : o_q;
  function automatic logic [7:0] rd(input logic [23:0] s);
    logic        bsy;
    logic [15:0] w;
    bsy = $realtime < busy_t;
    w = fl.exists(s[15:0]) ? fl[s[15:0]] : 16'hffff;
    case (s[23:16])
      8'h20: return bsy ? 8'hff : w[7:0];
      8'h28: return bsy ? 8'hff : w[15:8];
      8'ha0: return (bsy || !ee.exists(s[15:0])) ? 8'hff : ee[s[15:0]];
      8'hf0: return {7'h00, bsy};
      default: return s[7:0];
    endcase
  endfunction : rd
  task automatic exec(input logic [31:0] s);
    if (s[31:16] == 16'hac53) en_q = 1'b1;
    else if (en_q) begin
      busy_t = $realtime + BUSY_NS;
      case (s[31:24])
        8'hac: case (s[23:16])
          8'h80: begin fl.delete(); ee.delete(); end
          8'he0: fz_q[0] = s[7:0];
          8'ha0: fz_q[1] = s[7:0];
          8'ha8: fz_q[2] = s[7:0];
          default: ;
        endcase
        8'h40: pb[s[13:8]][7:0] = s[7:0];
        8'h48: pb[s[13:8]][15:8] = s[7:0];
        8'h4c: for (int i = 0; i < 64; i++) begin
          fl[{s[20:14], 6'(i)}] = pb[i];
          pb[i] = 16'hffff;
        end
        8'hc0: ee[s[23:8]] = s[7:0];
        default: ;
      endcase
    end
  endtask : exec
  always @(posedge sck) begin
    if (!rst) begin
      sh = {sh[30:0], mosi};
      n++;
      if (n == 16) ob = bad_echo ? ~sh[7:0] : sh[7:0];
      else if (n == 24) ob = rd(sh[23:0]);
      else if (n % 8 == 0) ob = sh[7:0];
      if (n == 32) exec(sh);
      if (n == 32) n = 0;
    end
  end
  always @(negedge sck) if (!rst) o_q = ob[7 - (n % 8)];
  // Reset high leaves programming mode and resynchronises framing
  always @(posedge rst) begin
    en_q = 1'b0;
    n = 0;
  end
endmodule : isp_dev_model
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module testbench;
  logic        clk_sys = 1'b0;
  logic        nrst, cmd_valid, cmd_ready, rsp_valid, rsp_err, prog_enabled;
  logic        isp_sck, isp_mosi, isp_reset, isp_miso, bad_echo;
  logic [3:0]  cmd_op;
  logic [3:0]  fops [3];
  logic [15:0] cmd_addr, a;
  logic [15:0] w [3];
  logic [7:0]  cmd_data, rsp_data, d;
  logic [6:0]  pg;
  logic [9:0]  exp_q [$];
  logic [9:0]  e;
  int          err_count = 0, cmp_count = 0, seed, i;
  always #5 clk_sys = ~clk_sys;
  isp_host #(.POWERUP_CYC(50), .FLASH_WAIT_CYC(50), .FUSE_WAIT_CYC(50),
    .EEPROM_WAIT_CYC(50), .ERASE_WAIT_CYC(50)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_err(rsp_err), .prog_enabled(prog_enabled), .isp_sck(isp_sck),
    .isp_mosi(isp_mosi), .isp_reset(isp_reset), .isp_miso(isp_miso));
  isp_dev_model dev (.sck(isp_sck), .mosi(isp_mosi), .rst(isp_reset),
    .bad_echo(bad_echo), .miso(isp_miso));
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // Expectation is {check data, error, data}
  task automatic cmd(input logic [3:0] op, input logic [15:0] ad, input logic [7:0] dt,
                     input logic [9:0] ex);
    exp_q.push_back(ex);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = ad;
    cmd_data = dt;
    for (int k = 0; k < 20000 && rsp_valid !== 1'b1; k++) @(negedge clk_sys);
    if (rsp_valid !== 1'b1) err_count++;
    cmd_valid = 1'b0;
  endtask : cmd
  // No response comes for these, so the request lasts exactly one edge
  task automatic pulse(input logic [3:0] op);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_op = op;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask : pulse
  task automatic wait_ready();
    for (int k = 0; k < 2000 && cmd_ready !== 1'b1; k++) @(negedge clk_sys);
    `CHK("cmd_ready", 1'b1, cmd_ready)
  endtask : wait_ready
  always @(negedge clk_sys) begin
    if (rsp_valid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 10'bx;
      `CHK("rsp_err", e[8], rsp_err)
      if (e[9]) `CHK("rsp_data", e[7:0], rsp_data)
    end
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    err_count++;
    test_done();
  end
  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    seed = 81909;
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 4'h0;
    cmd_addr = 16'h0000;
    cmd_data = 8'h00;
    bad_echo = 1'b0;
    fops = '{isp_pkg::ISP_CMD_WR_LOCK, isp_pkg::ISP_CMD_WR_FUSE_LO, isp_pkg::ISP_CMD_WR_FUSE_HI};
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    wait_ready();
    cmd(isp_pkg::ISP_CMD_ERASE, 16'h0000, 8'h00, 10'h100);
    cmd(isp_pkg::ISP_CMD_ENABLE, 16'h0000, 8'h00, 10'h000);
    `CHK("prog_enabled", 1'b1, prog_enabled)
    cmd(isp_pkg::ISP_CMD_ERASE, 16'h0000, 8'h00, 10'h000);
    a = 16'($random(seed));
    cmd(isp_pkg::ISP_CMD_RD_EE, a, 8'h00, 10'h2ff);
    pg = 7'($random(seed));
    cmd(isp_pkg::ISP_CMD_LOAD_HI, {3'b000, pg, 6'h00}, 8'h00, 10'h100);
    for (i = 0; i < 3; i++) w[i] = (i < 2) ? 16'($random(seed)) : 16'hffff;
    for (i = 0; i < 2; i++) begin
      cmd(isp_pkg::ISP_CMD_LOAD_LO, {3'b000, pg, 6'(i)}, w[i][7:0], 10'h000);
      cmd(isp_pkg::ISP_CMD_LOAD_HI, {3'b000, pg, 6'(i)}, w[i][15:8], 10'h000);
    end
    cmd(isp_pkg::ISP_CMD_WR_PAGE, {3'b000, pg, 6'h00}, 8'h00, 10'h000);
    for (i = 0; i < 3; i++) begin
      cmd(isp_pkg::ISP_CMD_RD_LO, {3'b000, pg, 6'(i)}, 8'h00, {2'b10, w[i][7:0]});
      cmd(isp_pkg::ISP_CMD_RD_HI, {3'b000, pg, 6'(i)}, 8'h00, {2'b10, w[i][15:8]});
    end
    for (i = 0; i < 2; i++) begin
      d = 8'($random(seed));
      cmd(isp_pkg::ISP_CMD_WR_EE, a, d, 10'h000);
      cmd(isp_pkg::ISP_CMD_RD_EE, a, 8'h00, {2'b10, d});
    end
    cmd(isp_pkg::ISP_CMD_POLL, 16'h0000, 8'h00, 10'h200);
    for (i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      cmd(fops[i], 16'h0000, d, 10'h000);
      `CHK("fuse", d, dev.fz_q[i])
    end
    bad_echo = 1'b1;
    cmd(isp_pkg::ISP_CMD_ENABLE, 16'h0000, 8'h00, 10'h100);
    for (i = 0; i < 4000 && isp_reset !== 1'b1; i++) @(negedge clk_sys);
    `CHK("retry reset", 1'b1, isp_reset)
    bad_echo = 1'b0;
    wait_ready();
    `CHK("prog_enabled", 1'b0, prog_enabled)
    cmd(isp_pkg::ISP_CMD_RD_EE, a, 8'h00, 10'h100);
    cmd(isp_pkg::ISP_CMD_ENABLE, 16'h0000, 8'h00, 10'h000);
    pulse(isp_pkg::ISP_CMD_END);
    repeat (4) @(negedge clk_sys);
    `CHK("end reset", 1'b1, isp_reset)
    `CHK("end enabled", 1'b0, prog_enabled)
    `CHK("pending", 0, exp_q.size())
    test_done();
  end
endmodule : testbench
`default_nettype wire
